// ### chan_tag_cfg.svh
// constants for the channel tag interface control block
`ifndef CHAN_TAG_CFG_SVH
`define CHAN_TAG_CFG_SVH
// register byte addresses
`define CT_REG_CTRL     8'h00
`define CT_REG_STATUS   8'h04
`define CT_REG_RXDATA   8'h08
`define CT_REG_TXDATA   8'h0C
`define CT_REG_BAC      8'h10
// control field positions and reset value
`define CT_CTRL_FEAT    8
`define CT_CTRL_REGEN   9
`define CT_CTRL_SENSE   10
`define CT_CTRL_CLRPE   11
`define CT_CTRL_RESET   12'h0C0
// status byte bits
`define CT_ST_BUSY      4
`define CT_ST_CE        3
`define CT_ST_DE        2
`define CT_ST_UC        1
// command codes
`define CT_CMD_TEST     8'h00
`define CT_CMD_NOP      8'h03
`define CT_CMD_ALARM    8'h0B
`define CT_CMD_INS_CUR  8'h0F
`define CT_CMD_REM_CUR  8'h13
`define CT_CMD_SBA_STOP 8'h1F
`define CT_CMD_SBA_GO   8'h27
`define CT_CMD_KEYS     8'h1B
`define CT_CMD_WR_DIR   8'h01
`define CT_CMD_WR_BUF   8'h05
`define CT_CMD_RD_INIT  8'h02
`define CT_CMD_RD_BUF   8'h06
`define CT_CMD_RD_CUR   8'h0E
`define CT_CMD_RD_MAN   8'h0A
`define CT_CMD_RD_POS   8'h12
`define CT_CMD_SENSE    8'h04
`endif

// ### chan_tag_pkg.sv
// types for the channel tag interface control block
package chan_tag_pkg;
   typedef enum logic [9:0] {
      S_IDLE   = 10'h001,
      S_WSEL   = 10'h002,
      S_WADR   = 10'h004,
      S_ADRIN  = 10'h008,
      S_STAT   = 10'h010,
      S_STDROP = 10'h020,
      S_SVC    = 10'h040,
      S_SACK   = 10'h080,
      S_END    = 10'h100,
      S_EDROP  = 10'h200
   } state_t;
endpackage : chan_tag_pkg

// ### tag_sync.sv
// two flip-flop synchroniser for channel pins
`timescale 1ns/1ns
module tag_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   if (WIDTH < 1)
   begin : g_width_check
      $error("tag_sync: WIDTH must be at least 1");
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : tag_sync

// ### cmd_decode.sv
// command code decoder and validity classes
`timescale 1ns/1ns
`include "chan_tag_cfg.svh"
module cmd_decode (
   input  wire logic [7:0] code,
   output logic            valid,
   output logic            is_test,
   output logic            no_data,
   output logic            wcount,
   output logic            dir_in,
   output logic [2:0]      len,
   output logic            need_buf
);
   always_comb
   begin
      valid    = 1'b1;
      is_test  = 1'b0;
      no_data  = 1'b0;
      wcount   = 1'b0;
      dir_in   = 1'b0;
      len      = 3'h0;
      need_buf = 1'b0;
      case (code)
         `CT_CMD_TEST:    begin is_test = 1'b1; no_data = 1'b1; end
         `CT_CMD_NOP,
         `CT_CMD_ALARM:   no_data = 1'b1;
         `CT_CMD_INS_CUR,
         `CT_CMD_REM_CUR: begin no_data = 1'b1; need_buf = 1'b1; end
         `CT_CMD_SBA_STOP,
         `CT_CMD_SBA_GO:  begin len = 3'h2; need_buf = 1'b1; end
         `CT_CMD_KEYS:    len = 3'h4;
         `CT_CMD_WR_DIR:  wcount = 1'b1;
         `CT_CMD_WR_BUF:  begin wcount = 1'b1; need_buf = 1'b1; end
         `CT_CMD_RD_INIT: begin wcount = 1'b1; dir_in = 1'b1; end
         `CT_CMD_RD_BUF:  begin wcount = 1'b1; dir_in = 1'b1; need_buf = 1'b1; end
         `CT_CMD_RD_CUR:  begin len = 3'h1; dir_in = 1'b1; need_buf = 1'b1; end
         `CT_CMD_RD_MAN:  begin len = 3'h3; dir_in = 1'b1; end
         `CT_CMD_RD_POS,
         `CT_CMD_SENSE:   begin len = 3'h4; dir_in = 1'b1; end
         default:         valid = 1'b0;
      endcase
   end
endmodule : cmd_decode

// ### channel_tag_interface_control.sv
// channel tag interface control: selection, service cycles, ending
`timescale 1ns/1ns
`include "chan_tag_cfg.svh"
module channel_tag_interface_control
   import chan_tag_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // channel tags and bus out
   input  wire logic        OP_OUT,
   input  wire logic        ADR_OUT,
   input  wire logic        SEL_OUT,
   input  wire logic        HOLD_OUT,
   input  wire logic        CMD_OUT,
   input  wire logic        SRV_OUT,
   input  wire logic [7:0]  BUS_OUT,
   input  wire logic        BUS_OUT_P,
   // channel tags and bus in
   output logic             OP_IN,
   output logic             ADR_IN,
   output logic             STA_IN,
   output logic             SRV_IN,
   output logic             SEL_PASS,
   output logic      [7:0]  BUS_IN,
   output logic             BUS_IN_P,
   // display datapath side
   input  wire logic [7:0]  RD_BYTE,
   output logic             RD_TAKE,
   output logic      [7:0]  WR_BYTE,
   output logic             WR_STROBE,
   output logic      [4:0]  TIMING_PERIOD
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [7:0] bo;
   logic       bop, op_o, adr_o, sel_o, hold_o, cmd_o, srv_o;
   tag_sync #(.WIDTH(15)) u_sync (
      .clk (CLK),
      .rst (SYS_RST),
      .d   ({BUS_OUT_P, BUS_OUT, OP_OUT, ADR_OUT, SEL_OUT, HOLD_OUT, CMD_OUT, SRV_OUT}),
      .q   ({bop, bo, op_o, adr_o, sel_o, hold_o, cmd_o, srv_o})
   );

   ////////////////////////////////////////////////////////////////////////////
   // state and registers
   state_t      state, next_state;
   logic [11:0] ctrl;
   logic [31:0] rxdata, txdata;
   logic [15:0] bac;
   logic [7:0]  cmd, sense;
   logic [2:0]  load_cnt;
   logic        parity_err, command_accepted_flag, end_now, trap;
   logic        console_sel, inhibit, word_hold, even_cnt, svc_req, gate_data;
   logic [4:0]  tp_q;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   wire         ahb_wr = wr_pend;

   ////////////////////////////////////////////////////////////////////////////
   // command decode and validation
   logic       c_valid, c_test, c_buf;
   cmd_decode u_dec (
      .code     (bo),
      .valid    (c_valid),
      .is_test  (c_test),
      .no_data  (),
      .wcount   (),
      .dir_in   (),
      .len      (),
      .need_buf (c_buf)
   );
   logic       l_test, l_nodata, l_wc, l_in;
   logic [2:0] l_len;
   cmd_decode u_ldec (
      .code     (cmd),
      .valid    (),
      .is_test  (l_test),
      .no_data  (l_nodata),
      .wcount   (l_wc),
      .dir_in   (l_in),
      .len      (l_len),
      .need_buf ()
   );

   wire good_par  = ^{bo, bop};
   wire ready     = !parity_err && !ctrl[`CT_CTRL_SENSE] && (state == S_IDLE);
   wire addr_hit  = op_o && adr_o && good_par && (bo == ctrl[7:0]) && ready;
   wire invalid   = !c_valid || !good_par;
   wire reject    = c_valid && c_buf &&
                    (!ctrl[`CT_CTRL_FEAT] || ctrl[`CT_CTRL_REGEN]);
   wire busy_cmd  = ctrl[`CT_CTRL_SENSE] && !c_test;
   wire unit_chk  = (invalid || reject) && !c_test;
   wire accept    = !invalid && !reject && !busy_cmd;
   wire [7:0] sel_status = {3'h0, busy_cmd, unit_chk, unit_chk, unit_chk, 1'b0} &
                           {3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   wire [7:0] end_status = 8'h0C | {6'h0, (parity_err && !l_test), 1'b0};
   wire last_fixed = !l_wc && (load_cnt == l_len);
   wire [7:0] tx_sel  = txdata[8*load_cnt[1:0] +: 8];
   wire [7:0] out_byte = l_wc ? RD_BYTE :
                         (cmd == `CT_CMD_SENSE) ? ((load_cnt == 3'h0) ? sense : 8'h00) :
                         tx_sel;

   ////////////////////////////////////////////////////////////////////////////
   // timing period coincidences
   wire [4:0] tp_c;
   // ending status also meets service out; only selection status opens period one
   assign tp_c[0] = STA_IN && srv_o && command_accepted_flag && (state == S_STAT);
   assign tp_c[1] = SRV_IN && !srv_o && console_sel;
   assign tp_c[2] = SRV_IN && srv_o && console_sel;
   assign tp_c[3] = !SRV_IN && srv_o && console_sel && !inhibit;
   assign tp_c[4] = SRV_IN && cmd_o;
   wire [4:0] tp_rise = tp_c & ~tp_q;

   ////////////////////////////////////////////////////////////////////////////
   // sequence state machine
   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:   if (addr_hit) next_state = S_WSEL;
         S_WSEL:
         begin
            if (sel_o && hold_o) next_state = S_WADR;
            else if (!adr_o) next_state = S_IDLE;
         end
         S_WADR:   if (!adr_o) next_state = S_ADRIN;
         S_ADRIN:  if (cmd_o && !sel_o && !hold_o) next_state = S_STAT;
         S_STAT:   if (srv_o && !cmd_o) next_state = S_STDROP;
         S_STDROP:
         begin
            if (!srv_o)
            begin
               if (end_now) next_state = S_IDLE;
               else if (l_nodata) next_state = S_END;
               else next_state = S_SVC;
            end
         end
         S_SVC:
         begin
            if (cmd_o) next_state = S_END;
            else if (srv_o) next_state = S_SACK;
         end
         S_SACK:
         begin
            if (!srv_o)
            begin
               if (last_fixed) next_state = S_END;
               else next_state = S_SVC;
            end
         end
         S_END:    if (srv_o || cmd_o) next_state = S_EDROP;
         S_EDROP:  if (!srv_o && !cmd_o) next_state = S_IDLE;
         default:  next_state = S_IDLE;
      endcase
   end

   wire go_adrin  = (state == S_WADR) && (next_state == S_ADRIN);
   wire go_stat   = (state == S_ADRIN) && (next_state == S_STAT);
   wire go_svc    = (next_state == S_SVC) && (state != S_SVC);
   wire go_end    = (next_state == S_END) && (state != S_END);
   wire take_byte = (state == S_SVC) && (next_state == S_SACK);
   wire done      = (state != S_IDLE) && (next_state == S_IDLE);

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // tag in and bus in drivers
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         OP_IN    <= 1'b0;
         ADR_IN   <= 1'b0;
         STA_IN   <= 1'b0;
         SRV_IN   <= 1'b0;
         BUS_IN   <= 8'h00;
         BUS_IN_P <= 1'b1;
         RD_TAKE  <= 1'b0;
      end
      else
      begin
         RD_TAKE <= 1'b0;
         if ((state == S_WSEL) && (next_state == S_WADR))
            OP_IN <= 1'b1;
         if (go_adrin)
         begin
            ADR_IN   <= 1'b1;
            BUS_IN   <= ctrl[7:0];
            BUS_IN_P <= ~^ctrl[7:0];
         end
         if (go_stat)
         begin
            ADR_IN   <= 1'b0;
            STA_IN   <= 1'b1;
            BUS_IN   <= sel_status;
            BUS_IN_P <= ~^sel_status;
         end
         if (next_state == S_STDROP && state == S_STAT)
            STA_IN <= 1'b0;
         if (go_svc)
         begin
            SRV_IN   <= 1'b1;
            BUS_IN   <= l_in ? out_byte : 8'h00;
            BUS_IN_P <= l_in ? ~^out_byte : 1'b1;
            RD_TAKE  <= l_in && l_wc;
         end
         if (take_byte)
            SRV_IN <= 1'b0;
         if (go_end)
         begin
            SRV_IN   <= 1'b0;
            STA_IN   <= 1'b1;
            BUS_IN   <= end_status;
            BUS_IN_P <= ~^end_status;
         end
         if (state == S_END && next_state == S_EDROP)
            STA_IN <= 1'b0;
         if (done)
         begin
            OP_IN  <= 1'b0;
            BUS_IN <= 8'h00;
            BUS_IN_P <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // select-out trap and command latch
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         trap     <= 1'b0;
         SEL_PASS <= 1'b0;
         cmd      <= 8'h00;
         end_now  <= 1'b0;
      end
      else
      begin
         if (addr_hit)
            trap <= 1'b1;
         else if (state == S_IDLE || done)
            trap <= 1'b0;
         SEL_PASS <= sel_o && !trap && !addr_hit;
         if (go_stat)
         begin
            cmd     <= bo;
            end_now <= (sel_status != 8'h00);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data movement and counters
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         load_cnt  <= 3'h0;
         rxdata    <= 32'h0000_0000;
         bac       <= 16'h0000;
         WR_BYTE   <= 8'h00;
         WR_STROBE <= 1'b0;
      end
      else
      begin
         WR_STROBE <= 1'b0;
         if (go_stat || done)
            load_cnt <= 3'h0;
         else if (take_byte)
            load_cnt <= load_cnt + 3'h1;
         if (tp_rise[0])
            bac <= 16'h0000;
         if (take_byte && !l_in)
         begin
            rxdata    <= {rxdata[23:0], bo};
            WR_BYTE   <= bo;
            WR_STROBE <= 1'b1;
            if (cmd == `CT_CMD_SBA_STOP || cmd == `CT_CMD_SBA_GO)
               bac <= {bac[7:0], bo};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing period latches
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         tp_q          <= 5'h00;
         TIMING_PERIOD <= 5'h00;
         console_sel   <= 1'b0;
         inhibit       <= 1'b0;
         even_cnt      <= 1'b0;
         svc_req       <= 1'b0;
         word_hold     <= 1'b0;
         gate_data     <= 1'b0;
      end
      else
      begin
         tp_q          <= tp_c;
         TIMING_PERIOD <= tp_rise;
         gate_data     <= tp_rise[1] && !l_wc && l_in;
         if (tp_rise[0])
         begin
            console_sel <= 1'b1;
            inhibit     <= 1'b1;
            even_cnt    <= 1'b1;
            svc_req     <= !l_nodata;
         end
         else if (done)
            console_sel <= 1'b0;
         if (tp_rise[1])
         begin
            svc_req   <= 1'b0;
            word_hold <= !l_wc && l_in;
         end
         if (tp_rise[2])
            inhibit <= 1'b0;
         if (tp_rise[3])
         begin
            word_hold <= 1'b0;
            even_cnt  <= ~even_cnt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accepted flag, sense and parity error
   wire pe_seen = (go_stat && !good_par) || (take_byte && !l_in && !good_par);
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         command_accepted_flag <= 1'b0;
         sense                 <= 8'h00;
         parity_err            <= 1'b0;
      end
      else
      begin
         if (go_stat)
            command_accepted_flag <= accept;
         else if (done)
            command_accepted_flag <= 1'b0;
         if (go_stat && unit_chk)
            sense <= sense | {7'h00, invalid} | {6'h00, reject, 1'b0};
         else if (go_stat && accept && !c_test && bo != `CT_CMD_SENSE)
            sense <= 8'h00;
         if (pe_seen)
            parity_err <= 1'b1;
         else if (ahb_wr && wr_addr == `CT_REG_CTRL && HWDATA[`CT_CTRL_CLRPE])
            parity_err <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   wire addr_ok = HSEL && HREADY && HTRANS[1];
   wire [7:0] a = HADDR[7:0];
   wire [31:0] rd_mux =
      (a == `CT_REG_CTRL)   ? {20'h0, ctrl} :
      (a == `CT_REG_STATUS) ? {sense, 2'h0, svc_req, gate_data, even_cnt, word_hold,
                               inhibit, console_sel, command_accepted_flag, parity_err,
                               state, 2'h0, trap, end_now} :
      (a == `CT_REG_RXDATA) ? rxdata :
      (a == `CT_REG_TXDATA) ? txdata :
      (a == `CT_REG_BAC)    ? {16'h0, bac} : 32'h0000_0000;

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         ctrl      <= `CT_CTRL_RESET;
         txdata    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= addr_ok && HWRITE;
         wr_addr <= a;
         if (addr_ok && !HWRITE)
            HRDATA <= rd_mux;
         if (wr_pend && wr_addr == `CT_REG_CTRL)
            ctrl <= {1'b0, HWDATA[10:0]};
         if (wr_pend && wr_addr == `CT_REG_TXDATA)
            txdata <= HWDATA;
      end
   end
endmodule : channel_tag_interface_control

// ### chan_tag_checker.sv
// assertions on the channel tag control ports
`timescale 1ns/1ns
module chan_tag_checker (
   // clock and reset
   input wire logic       CLK,
   input wire logic       SYS_RST,
   // channel tags out
   input wire logic       ADR_OUT,
   input wire logic       SEL_OUT,
   input wire logic       HOLD_OUT,
   input wire logic       CMD_OUT,
   input wire logic       SRV_OUT,
   // tags and bus in
   input wire logic       OP_IN,
   input wire logic       ADR_IN,
   input wire logic       STA_IN,
   input wire logic       SRV_IN,
   input wire logic       SEL_PASS,
   input wire logic [7:0] BUS_IN,
   input wire logic       BUS_IN_P,
   input wire logic       RD_TAKE,
   input wire logic [4:0] TIMING_PERIOD
);
   // the bench never changes the unit address from its reset value
   localparam logic [7:0] UNIT = 8'hC0;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // tags pass two synchroniser stages before the answer is registered
   sequence sel_seen;
      $past(SEL_OUT, 2) && $past(HOLD_OUT, 2);
   endsequence
   sequence answer_seen;
      $past(SRV_OUT, 2) || $past(CMD_OUT, 2);
   endsequence
   opin_rise_a :
      assert property ($rose(OP_IN) |-> sel_seen) else $error("op in rose unasked");
   adr_in_a :
      assert property ($rose(ADR_IN) |-> !$past(ADR_OUT, 2) && BUS_IN == UNIT)
      else $error("address in wrong");
   status_a :
      assert property ($fell(ADR_IN) |-> STA_IN && $past(CMD_OUT, 2))
      else $error("status in not after command");
   sta_drop_a :
      assert property ($fell(STA_IN) |-> answer_seen) else $error("status in dropped early");
   srv_drop_a :
      assert property ($fell(SRV_IN) |-> answer_seen) else $error("service in dropped early");
   opin_hold_a :
      assert property ((ADR_IN || STA_IN || SRV_IN) |-> OP_IN && ^{BUS_IN, BUS_IN_P})
      else $error("tag in without op in or bad parity");
   one_tag_a :
      assert property (!(STA_IN && SRV_IN)) else $error("status and service in together");
   opin_fall_a :
      assert property ($fell(OP_IN) |-> !(STA_IN || SRV_IN || ADR_IN))
      else $error("op in dropped mid sequence");
   trap_a :
      assert property (OP_IN |-> !SEL_PASS) else $error("select passed while selected");
   period_a :
      assert property (|TIMING_PERIOD |-> $onehot(TIMING_PERIOD) ##1
                       ((TIMING_PERIOD & $past(TIMING_PERIOD)) == 5'h00))
      else $error("timing periods overlap");
   period5_a :
      assert property (TIMING_PERIOD[4] |-> $past(CMD_OUT, 2)) else $error("period five unasked");
   rd_take_a :
      assert property (RD_TAKE |-> $rose(SRV_IN)) else $error("read byte taken off cycle");
endmodule : chan_tag_checker
////////////////////////////////////////////////////////////////////////////////
bind channel_tag_interface_control chan_tag_checker u_chk (.CLK, .SYS_RST, .ADR_OUT,
   .SEL_OUT, .HOLD_OUT, .CMD_OUT, .SRV_OUT, .OP_IN, .ADR_IN, .STA_IN, .SRV_IN, .SEL_PASS,
   .BUS_IN, .BUS_IN_P, .RD_TAKE, .TIMING_PERIOD);

// ### chan_model.sv
// behavioural channel driving tags and bus out
`timescale 1ns/1ns
module chan_model (
   // from the unit
   input  wire logic       clk,
   input  wire logic       op_in,
   input  wire logic       adr_in,
   input  wire logic       sta_in,
   input  wire logic       srv_in,
   input  wire logic [7:0] bus_in,
   // to the unit
   output logic            op_out,
   output logic            adr_out,
   output logic            sel_out,
   output logic            hold_out,
   output logic            cmd_out,
   output logic            srv_out,
   output logic      [7:0] bus_out,
   output logic            bus_out_p
);
   int         tmo = 0;
   logic [7:0] got;
   logic [7:0] got_adr;
   wire  [3:0] tags = {srv_in, sta_in, adr_in, op_in};
   assign bus_out_p = ~^bus_out;
   initial
   begin
      {op_out, adr_out, sel_out, hold_out, cmd_out, srv_out} = 6'h00;
      bus_out = 8'h5A;
   end
   // bounded wait; a silent unit counts as a fault, not a hang
   task automatic wt(input int k, input logic lvl);
      int n = 0;
      @(posedge clk);
      while (tags[k] !== lvl && n < 60)
      begin
         n++;
         @(posedge clk);
      end
      if (n == 60) tmo++;
   endtask : wt
   task automatic probe(input logic [7:0] a);
      @(posedge clk);
      op_out <= 1'b1; adr_out <= 1'b1; bus_out <= a;
      repeat (5) @(posedge clk);
      sel_out <= 1'b1; hold_out <= 1'b1;
   endtask : probe
   task automatic select(input logic [7:0] a, input logic [7:0] c);
      probe(a);
      wt(0, 1'b1);
      adr_out <= 1'b0; bus_out <= ~a;
      wt(1, 1'b1);
      got_adr = bus_in;
      sel_out <= 1'b0; hold_out <= 1'b0; cmd_out <= 1'b1; bus_out <= c;
      wt(2, 1'b1);
      got = bus_in;
      cmd_out <= 1'b0; srv_out <= 1'b1; bus_out <= ~c;
      wt(2, 1'b0);
      srv_out <= 1'b0;
   endtask : select
   task automatic quiet;
      @(posedge clk);
      {op_out, adr_out, sel_out, hold_out} <= 4'h0;
      bus_out <= ~bus_out;
   endtask : quiet
   task automatic wr(input logic [7:0] b);
      wt(3, 1'b1);
      srv_out <= 1'b1; bus_out <= b;
      wt(3, 1'b0);
      srv_out <= 1'b0; bus_out <= ~b;
   endtask : wr
   task automatic rd(output logic [7:0] b);
      wt(3, 1'b1);
      b = bus_in;
      srv_out <= 1'b1;
      wt(3, 1'b0);
      srv_out <= 1'b0;
   endtask : rd
   task automatic tail;
      wt(0, 1'b0);
      op_out <= 1'b0;
   endtask : tail
   task automatic fin;
      wt(2, 1'b1);
      got = bus_in;
      srv_out <= 1'b1;
      wt(2, 1'b0);
      srv_out <= 1'b0;
      tail;
   endtask : fin
   // word count exhausted: answer the last service in with command out
   task automatic stop(output logic [7:0] b);
      wt(3, 1'b1);
      b = bus_in;
      cmd_out <= 1'b1;
      wt(2, 1'b1);
      got = bus_in;
      wt(2, 1'b0);
      cmd_out <= 1'b0;
      tail;
   endtask : stop
endmodule : chan_model

// ### testbench.sv
// self-checking bench: register bus and channel sequences
`timescale 1ns/1ns
`include "chan_tag_cfg.svh"
module testbench;
   logic        CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
   logic [1:0]  HTRANS = 2'h0;
   logic [7:0]  RD_BYTE = 8'hA5;
   wire  [31:0] HRDATA;
   wire  [7:0]  BUS_OUT, BUS_IN, WR_BYTE;
   wire  [4:0]  TIMING_PERIOD;
   wire         HREADYOUT, HRESP, OP_OUT, ADR_OUT, SEL_OUT, HOLD_OUT, CMD_OUT, SRV_OUT;
   wire         BUS_OUT_P, OP_IN, ADR_IN, STA_IN, SRV_IN, SEL_PASS, BUS_IN_P, RD_TAKE;
   wire         WR_STROBE;
   int          err_count = 0, compares = 0, strobes = 0;
   logic [31:0] q;
   logic [7:0]  b;
   logic [7:0]  nd [5] = '{`CT_CMD_TEST, `CT_CMD_NOP, `CT_CMD_ALARM, `CT_CMD_INS_CUR,
                           `CT_CMD_REM_CUR};
   logic [7:0]  rdc [3] = '{`CT_CMD_RD_CUR, `CT_CMD_RD_MAN, `CT_CMD_RD_POS};
   logic [7:0]  wc [4] = '{`CT_CMD_WR_DIR, `CT_CMD_WR_BUF, `CT_CMD_RD_INIT, `CT_CMD_RD_BUF};
   int          cnt [3] = '{1, 3, 4};
   always #5 CLK = ~CLK;
   always @(posedge CLK) if (WR_STROBE === 1'b1) strobes++;
   channel_tag_interface_control dut (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
      .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA, .HRDATA, .HREADYOUT, .HRESP, .OP_OUT,
      .ADR_OUT, .SEL_OUT, .HOLD_OUT, .CMD_OUT, .SRV_OUT, .BUS_OUT, .BUS_OUT_P, .OP_IN,
      .ADR_IN, .STA_IN, .SRV_IN, .SEL_PASS, .BUS_IN, .BUS_IN_P, .RD_BYTE, .RD_TAKE,
      .WR_BYTE, .WR_STROBE, .TIMING_PERIOD);
   chan_model ch (.clk(CLK), .op_in(OP_IN), .adr_in(ADR_IN), .sta_in(STA_IN),
      .srv_in(SRV_IN), .bus_in(BUS_IN), .op_out(OP_OUT), .adr_out(ADR_OUT),
      .sel_out(SEL_OUT), .hold_out(HOLD_OUT), .cmd_out(CMD_OUT), .srv_out(SRV_OUT),
      .bus_out(BUS_OUT), .bus_out_p(BUS_OUT_P));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge CLK);
      HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      q = HRDATA;
   endtask : ahb
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rdchk
   task automatic finish_test;
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge CLK);
      err_count++;
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (3) @(posedge CLK);
      chk({HREADYOUT, HRESP, OP_IN, STA_IN, BUS_IN_P}, 5'h11);
      rdchk(`CT_REG_CTRL, 32'h0C0);
      rdchk(32'h20, 32'h0);
      ahb(1'b1, `CT_REG_CTRL, 32'h1C0);
      foreach (nd[i])
      begin
         ch.select(8'hC0, nd[i]);
         chk({ch.got_adr, ch.got}, 16'hC000);
         ch.fin;
         chk(ch.got, 8'h0C);
      end
      ch.select(8'hC0, `CT_CMD_SBA_GO);
      ch.wr(8'h12);
      ch.wr(8'h34);
      ch.fin;
      chk(ch.got, 8'h0C);
      rdchk(`CT_REG_BAC, 32'h1234);
      ch.select(8'hC0, `CT_CMD_KEYS);
      for (int j = 1; j <= 4; j++) ch.wr(8'(j));
      ch.fin;
      chk(ch.got, 8'h0C);
      rdchk(`CT_REG_RXDATA, 32'h01020304);
      chk(WR_BYTE, 8'h04);
      ahb(1'b1, `CT_REG_TXDATA, 32'h44332211);
      foreach (rdc[i])
      begin
         ch.select(8'hC0, rdc[i]);
         for (int j = 0; j < cnt[i]; j++)
         begin
            ch.rd(b);
            chk(b, 8'h11 * (j + 1));
         end
         ch.fin;
         chk(ch.got, 8'h0C);
      end
      foreach (wc[i])
      begin
         ch.select(8'hC0, wc[i]);
         for (int j = 0; j < 2; j++)
         begin
            if (i < 2) ch.wr(8'hA0 + 8'(j));
            else ch.rd(b);
            if (i >= 2) chk(b, 8'hA5);
         end
         ch.stop(b);
         chk(ch.got, 8'h0C);
      end
      rdchk(`CT_REG_RXDATA, 32'hA0A1A0A1);
      // unknown code, then test must leave the sense byte alone
      ch.select(8'hC0, 8'hFF);
      chk(ch.got, 8'h0E);
      ch.tail;
      ahb(1'b0, `CT_REG_STATUS, 32'h0);
      chk(q[24], 1'b1);
      ch.select(8'hC0, `CT_CMD_TEST);
      chk(ch.got, 8'h00);
      ch.fin;
      ahb(1'b0, `CT_REG_STATUS, 32'h0);
      chk(q[24], 1'b1);
      ch.select(8'hC0, `CT_CMD_SENSE);
      for (int j = 0; j < 4; j++)
      begin
         ch.rd(b);
         chk(b, j ? 8'h00 : 8'h01);
      end
      ch.fin;
      chk(ch.got, 8'h0C);
      // no buffer feature, then buffer regeneration running
      for (int i = 0; i < 2; i++)
      begin
         ahb(1'b1, `CT_REG_CTRL, i ? 32'h3C0 : 32'h0C0);
         ch.select(8'hC0, i ? `CT_CMD_WR_BUF : `CT_CMD_SBA_STOP);
         chk(ch.got, 8'h0E);
         ch.tail;
      end
      // sense request pending, then a foreign address: no selection
      for (int i = 0; i < 2; i++)
      begin
         ahb(1'b1, `CT_REG_CTRL, i ? 32'h0C0 : 32'h4C0);
         ch.probe(i ? 8'h55 : 8'hC0);
         repeat (10) @(posedge CLK);
         chk({OP_IN, SEL_PASS}, 2'b01);
         ch.quiet;
         repeat (4) @(posedge CLK);
      end
      chk(strobes, 10);
      chk(ch.tmo, 0);
      finish_test;
   end
endmodule : testbench
